// [inc/sar_cfg.svh]
// Purpose: constants of the serial conversion and readout block
// Assumes: 40 MHz system clock
// Notes:   conversion limits are plain defaults, override per part
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_RES_BITS      18
`define SAR_BITS_PLAIN    18
`define SAR_BITS_BUSY     19
`define SAR_CLK_PERIOD_NS 25
`define SAR_CONV_MIN_NS   500
`define SAR_CONV_MAX_NS   710
`define SAR_TCNT_BITS     8
`define SAR_BCNT_BITS     5
`define SAR_BUF_DEPTH     2

`endif

// [inc/sar_pkg.sv]
// Purpose: shared types of the serial conversion and readout block
// Assumes: sar_cfg.svh on the include path
// Notes:   constants live in the header, types here
`include "sar_cfg.svh"

package sar_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CONV  = 4'h2,
    ST_HOLD  = 4'h4,
    ST_SHIFT = 4'h8
  } sar_state_t;

  typedef struct packed {
    logic convert_strobe;
    logic chain_select_in;
    logic sclk;
  } sar_pins_t;

  typedef struct packed {
    logic level;
    logic oe;
  } sar_pin_out_t;

  typedef struct packed {
    sar_state_t                 st;
    sar_pins_t                  s1;
    sar_pins_t                  s2;
    sar_pins_t                  s3;
    logic                       chain;
    logic                       busy;
    logic [`SAR_TCNT_BITS-1:0]  tcnt;
    logic [`SAR_BCNT_BITS-1:0]  bcnt;
    logic [`SAR_RES_BITS-1:0]   sh;
    sar_pin_out_t               pin;
    logic                       acq;
    logic                       start;
  } sar_regs_t;

endpackage

// [logic/sar_buf.sv]
// Purpose: small shift-style fifo between converter core and readout
// Assumes: single clock, head entry always at index 0
// Notes:   all outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"

module sar_buf #(
  parameter int W     = `SAR_RES_BITS,
  parameter int DEPTH = `SAR_BUF_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  // drain side
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    valid;
    logic                    ready;
  } sar_buf_regs_t;

  sar_buf_regs_t r_q;
  sar_buf_regs_t r_d;

  always_comb begin
    r_d = r_q;
    if (out_ready && r_q.valid) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        r_d.mem[i] = r_q.mem[i+1];
      end
      r_d.cnt = r_d.cnt - CW'(1);
    end
    if (in_valid && r_q.ready) begin
      r_d.mem[r_d.cnt] = in_data;
      r_d.cnt = r_d.cnt + CW'(1);
    end
    r_d.valid = (r_d.cnt != '0);
    r_d.ready = (r_d.cnt < CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q       <= '0;
      r_q.ready <= 1'b1;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign in_ready  = r_q.ready;
  assign out_valid = r_q.valid;
  assign out_data  = r_q.mem[0];

endmodule

`default_nettype wire

// [logic/sar_readout.sv]
// Purpose: conversion start, mode pick and serial shift-out of a sar converter
// Assumes: pins and serial clock asynchronous, sampled by clk
// Notes:   result word comes from the converter core over a valid/ready stream
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"

module sar_readout #(
  parameter int T_CONV_MIN_NS = `SAR_CONV_MIN_NS,
  parameter int T_CONV_MAX_NS = `SAR_CONV_MAX_NS,
  parameter int BUF_DEPTH     = `SAR_BUF_DEPTH
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  // converter pins
  input  wire logic                     convert_strobe,
  input  wire logic                     chain_select_in,
  input  wire logic                     sclk,
  output var  logic                     result_out,
  output var  logic                     result_out_oe,
  // result stream from the converter core
  input  wire logic                     res_valid,
  input  wire logic [`SAR_RES_BITS-1:0] res_data,
  output var  logic                     res_ready,
  // status
  output var  logic                     conv_start,
  output var  logic                     acquiring,
  output var  logic                     chain_mode,
  output var  logic                     busy_armed
);

  localparam int TW = `SAR_TCNT_BITS;
  localparam int BW = `SAR_BCNT_BITS;
  localparam int RB = `SAR_RES_BITS;

  // least time rounds up, longest rounds down, never below one cycle
  localparam int MIN_RAW = (T_CONV_MIN_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS;
  localparam int MAX_RAW = T_CONV_MAX_NS / `SAR_CLK_PERIOD_NS;
  localparam logic [TW-1:0] CONV_MIN_CYC = TW'((MIN_RAW < 1) ? 1 : MIN_RAW);
  localparam logic [TW-1:0] CONV_MAX_CYC = TW'((MAX_RAW < 1) ? 1 : MAX_RAW);

  localparam logic [BW-1:0] LAST_PLAIN = BW'(`SAR_BITS_PLAIN);
  localparam logic [BW-1:0] LAST_BUSY  = BW'(`SAR_BITS_BUSY);

  sar_pkg::sar_regs_t r_q;
  sar_pkg::sar_regs_t r_d;

  logic          buf_valid;
  logic [RB-1:0] buf_data;
  logic          buf_pop;

  // falls needed to finish a chip-select readout
  function automatic logic [BW-1:0] last_fall(input logic busy);
    last_fall = busy ? LAST_BUSY : LAST_PLAIN;
  endfunction

  sar_buf #(
    .W     (RB),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (res_valid),
    .in_data   (res_data),
    .in_ready  (res_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  logic cnv_hi;
  logic sel_hi;
  logic cnv_rise;
  logic cnv_fall;
  logic sel_rise;
  logic sclk_fall;
  logic conv_done;

  always_comb begin
    cnv_hi    = r_q.s2.convert_strobe;
    sel_hi    = r_q.s2.chain_select_in;
    cnv_rise  = cnv_hi & ~r_q.s3.convert_strobe;
    cnv_fall  = ~cnv_hi & r_q.s3.convert_strobe;
    sel_rise  = sel_hi & ~r_q.s3.chain_select_in;
    sclk_fall = ~r_q.s2.sclk & r_q.s3.sclk;
    conv_done = ((r_q.tcnt >= CONV_MIN_CYC) && buf_valid) || (r_q.tcnt >= CONV_MAX_CYC);
  end

  always_comb begin
    r_d       = r_q;
    buf_pop   = 1'b0;
    r_d.start = 1'b0;
    // two-stage synchroniser, third stage only for edge finding
    r_d.s1.convert_strobe  = convert_strobe;
    r_d.s1.chain_select_in = chain_select_in;
    r_d.s1.sclk            = sclk;
    r_d.s2                 = r_q.s1;
    r_d.s3                 = r_q.s2;

    case (r_q.st)
      sar_pkg::ST_IDLE: begin
        r_d.pin.level = 1'b0;
        r_d.pin.oe    = ~cnv_hi & ~sel_hi;
      end
      sar_pkg::ST_CONV: begin
        r_d.pin.oe = 1'b0;
        r_d.tcnt   = r_q.tcnt + TW'(1);
        if (conv_done) begin
          buf_pop  = buf_valid;
          r_d.sh   = buf_valid ? buf_data : '0;
          r_d.acq  = 1'b1;
          r_d.bcnt = '0;
          r_d.busy = ~r_q.chain & (~cnv_hi | ~sel_hi);
          if (r_q.chain) begin
            r_d.pin.oe    = 1'b1;
            r_d.pin.level = buf_valid ? buf_data[RB-1] : 1'b0;
            r_d.st        = sar_pkg::ST_SHIFT;
          end else if (~cnv_hi | ~sel_hi) begin
            r_d.pin.oe    = 1'b1;
            r_d.pin.level = 1'b0;
            r_d.st        = sar_pkg::ST_SHIFT;
          end else begin
            r_d.st = sar_pkg::ST_HOLD;
          end
        end
      end
      sar_pkg::ST_HOLD: begin
        // three-wire selects by strobe, four-wire by chain input
        if (~cnv_hi | ~sel_hi) begin
          r_d.pin.oe    = 1'b1;
          r_d.pin.level = r_q.sh[RB-1];
          r_d.st        = sar_pkg::ST_SHIFT;
        end
      end
      sar_pkg::ST_SHIFT: begin
        if (r_q.chain ? cnv_fall : sel_rise) begin
          r_d.pin.oe = 1'b0;
          r_d.st     = sar_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          r_d.bcnt = r_q.bcnt + BW'(1);
          if (r_q.busy && r_q.bcnt == '0) begin
            r_d.pin.level = r_q.sh[RB-1];
          end else begin
            r_d.sh        = {r_q.sh[RB-2:0], r_q.chain & sel_hi};
            r_d.pin.level = r_q.sh[RB-2];
          end
          if (!r_q.chain && (r_q.bcnt + BW'(1)) == last_fall(r_q.busy)) begin
            r_d.pin.oe = 1'b0;
            r_d.st     = sar_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        r_d.st     = sar_pkg::ST_IDLE;
        r_d.pin.oe = 1'b0;
      end
    endcase

    // new conversion overrides any readout, which also ends a three-wire read
    if (cnv_rise && r_q.st != sar_pkg::ST_CONV) begin
      r_d.chain  = ~sel_hi;
      r_d.busy   = 1'b0;
      r_d.pin.oe = 1'b0;
      r_d.tcnt   = '0;
      r_d.acq    = 1'b0;
      r_d.start  = 1'b1;
      r_d.st     = sar_pkg::ST_CONV;
    end
  end

  // output stage may meet other drivers; nothing here needs to prevent it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q     <= '0;
      r_q.st  <= sar_pkg::ST_IDLE;
      r_q.acq <= 1'b1;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign result_out    = r_q.pin.level;
  assign result_out_oe = r_q.pin.oe;
  assign conv_start    = r_q.start;
  assign acquiring     = r_q.acq;
  assign chain_mode    = r_q.chain;
  assign busy_armed    = r_q.busy;

endmodule

`default_nettype wire

// [verif/sar_readout_sva.sv]
// Purpose: assertions on pins and status of sar_readout
// Assumes: host keeps pins steady around the sampled moments
// Notes:   bound into every sar_readout
`timescale 1ns/1ps
`default_nettype none

module sar_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins
  input wire logic convert_strobe,
  input wire logic chain_select_in,
  input wire logic result_out,
  input wire logic result_out_oe,
  // status
  input wire logic conv_start,
  input wire logic acquiring,
  input wire logic chain_mode,
  input wire logic busy_armed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_conv; !acquiring [*8] ##1 !acquiring [*8] ##[4:13] acquiring; endsequence
  property p_start; $rose(convert_strobe) && acquiring |-> ##[2:4] conv_start; endproperty
  property p_conv_float; !acquiring |-> !result_out_oe; endproperty
  property p_busy; $rose(acquiring) && busy_armed |-> result_out_oe && !result_out; endproperty
  property p_conv; conv_start |=> s_conv; endproperty
  property p_strobe_fl; $rose(convert_strobe) |-> ##[2:4] !result_out_oe; endproperty
  property p_sel_fl; !chain_mode && $rose(chain_select_in) |-> ##[2:4] !result_out_oe; endproperty
  property p_mode; conv_start |=> chain_mode == !$past(chain_select_in, 4); endproperty
  property p_chain_busy; chain_mode && $rose(acquiring) |-> !busy_armed; endproperty
  property p_busy_sel; !chain_mode && $rose(acquiring) |->
    busy_armed == !($past(convert_strobe, 3) && $past(chain_select_in, 3)); endproperty
  a_start: assert property (p_start) else $error("no start after strobe rise");
  a_conv_float: assert property (p_conv_float) else $error("driven in conversion");
  a_busy: assert property (p_busy) else $error("no low drive at busy end");
  a_conv: assert property (p_conv) else $error("conversion length off");
  a_strobe_fl: assert property (p_strobe_fl) else $error("no float on strobe rise");
  a_sel_fl: assert property (p_sel_fl) else $error("no float on select rise");
  a_mode: assert property (p_mode) else $error("wrong mode latched");
  a_chain_busy: assert property (p_chain_busy) else $error("busy in chain mode");
  a_busy_sel: assert property (p_busy_sel) else $error("busy choice wrong");
endmodule

bind sar_readout sar_chk i_chk (.clk, .resetn, .convert_strobe, .chain_select_in,
  .result_out, .result_out_oe, .conv_start, .acquiring, .chain_mode, .busy_armed);

`default_nettype wire

// [verif/sar_host.sv]
// Purpose: host model driving strobe, chain input and serial clock
// Assumes: result line resolved with pull-up by the bench
// Notes:   serial clock 200 ns, stands still between frames
`timescale 1ns/1ps
`default_nettype none

module sar_host (
  // clock
  input  wire logic clk,
  // pins
  input  wire logic res_line,
  output var  logic convert_strobe,
  output var  logic chain_select_in,
  output var  logic sclk
);
  initial begin
    convert_strobe = 1'b0;
    chain_select_in = 1'b0;
    sclk = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // serial clock low first so chain entry sees it low
  task automatic start(input logic sel);
    sclk <= 1'b0;
    convert_strobe <= 1'b0;
    chain_select_in <= sel;
    cyc(6);
    convert_strobe <= 1'b1;
    cyc(4);
  endtask
  task automatic pins(input logic cv, input logic sel);
    convert_strobe <= cv;
    chain_select_in <= sel;
    cyc(5);
  endtask
  // one sample before the first fall, one in the high phase after each fall
  task automatic frame(input int n, output logic [19:0] v);
    v = '0;
    sclk <= 1'b1;
    cyc(4);
    v = {v[18:0], res_line};
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      cyc(4);
      sclk <= 1'b1;
      cyc(2);
      v = {v[18:0], res_line};
      cyc(2);
    end
  endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench of sar_readout with a host model
// Assumes: result line pulled up when not driven
// Notes:   one task per scenario, verdict in print_verdict
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"

module testbench;
  localparam logic [17:0] W1 = 18'h2D1E7;
  localparam logic [17:0] W2 = 18'h1A5B6;
  localparam logic [17:0] W3 = 18'h3C00F;
  localparam logic [17:0] W4 = 18'h25A93;
  logic                      clk;
  logic                      resetn;
  logic                      res_valid;
  logic [`SAR_RES_BITS-1:0]  res_data;
  logic                      res_ready;
  logic                      result_out;
  logic                      result_out_oe;
  logic                      chain_mode;
  logic                      busy_armed;
  logic                      acquiring;
  logic                      convert_strobe;
  logic                      chain_select_in;
  logic                      sclk;
  logic [19:0]               v;
  int                        n_fail;
  int                        n_checks;
  wire                       res_line = result_out_oe ? result_out : 1'b1;

  sar_readout i_dut (.clk, .resetn, .ce(1'b1), .convert_strobe, .chain_select_in, .sclk,
    .result_out, .result_out_oe, .res_valid, .res_data, .res_ready, .conv_start(),
    .acquiring, .chain_mode, .busy_armed);
  sar_host i_host (.clk, .res_line, .convert_strobe, .chain_select_in, .sclk);

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [17:0] w);
    res_valid <= 1'b1;
    res_data <= w;
    do @(posedge clk); while (res_ready !== 1'b1);
    res_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // two words fill the buffer, core side then refused
  task automatic t_buf;
    push(W1);
    push(W2);
    repeat (2) @(posedge clk);
    chk({19'h0, res_ready}, 20'h0);
  endtask
  task automatic t_busy3;
    i_host.start(1'b1);
    i_host.pins(1'b0, 1'b1);
    chk({18'h0, acquiring, res_line}, 20'h1);
    repeat (40) @(posedge clk);
    chk({17'h0, acquiring, busy_armed, res_line}, 20'h6);
    i_host.frame(19, v);
    chk(v, {1'b0, W1, 1'b1});
  endtask
  task automatic t_nobusy4;
    i_host.start(1'b1);
    repeat (40) @(posedge clk);
    chk({18'h0, busy_armed, res_line}, 20'h1);
    i_host.pins(1'b1, 1'b0);
    i_host.frame(18, v);
    chk(v, {1'b0, W2, 1'b1});
  endtask
  task automatic t_busy4;
    push(W3);
    i_host.start(1'b1);
    i_host.pins(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk({18'h0, busy_armed, res_line}, 20'h2);
    i_host.frame(4, v);
    i_host.pins(1'b1, 1'b1);
    chk({14'h0, v[4:0], res_line}, {14'h0, 1'b0, W3[17:14], 1'b1});
  endtask
  task automatic t_chain;
    push(W4);
    i_host.start(1'b0);
    i_host.pins(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    chk({18'h0, chain_mode, busy_armed}, 20'h2);
    i_host.frame(18, v);
    chk(v, {1'b0, W4, 1'b1});
    chk({19'h0, result_out_oe}, 20'h1);
    i_host.pins(1'b0, 1'b1);
    chk({19'h0, result_out_oe}, 20'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    res_valid = 1'b0;
    res_data = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk({19'h0, res_line}, 20'h0);
    t_buf;
    t_busy3;
    t_nobusy4;
    t_busy4;
    t_chain;
    print_verdict;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule

`default_nettype wire
